// ### rtl/tcm_timer.sv
// one 16-bit up-counting timer channel with start, clock, clear and capture control
// assumes apb master on ref_clk; pins are synchronous to ref_clk
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module tcm_timer
    import tcm_pkg::*;
#(
    parameter int ADDR_W = 8
)(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // pins and system levels
    input  wire logic              timer_input_pin,
    input  wire logic              idle_mode,
    input  wire logic              sync_start_in,
    output logic                   timer_flipflop_out,
    output logic                   count_running
);

    // address match, used by read and write decode
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        hit = (a == ADDR_W'(off));
    endfunction : hit

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = hit(a, OFF_ENABLE) | hit(a, OFF_RUN) | hit(a, OFF_CONTROL) | hit(a, OFF_MODE)
               | hit(a, OFF_FFCTRL) | hit(a, OFF_UPCOUNT) | hit(a, OFF_CMP0) | hit(a, OFF_CMP1)
               | hit(a, OFF_CAP0) | hit(a, OFF_CAP1);
    endfunction : mapped

    // registers
    logic              blk_en_q;
    logic              cnt_run_q;
    logic              presc_run_q;
    logic [7:0]        ctrl_q;
    logic [7:0]        mode_q;
    logic [3:0]        fftgl_q;
    logic [15:0]       cmp0_buf_q;
    logic [15:0]       cmp1_buf_q;
    logic [15:0]       cmp0_q;
    logic [15:0]       cmp1_q;
    logic [15:0]       cap0_q;
    logic [15:0]       cap1_q;
    logic [15:0]       cnt_q;
    logic              ff_q;
    logic              ff_prev_q;
    logic              pin_prev_q;
    logic              running_q;
    logic [31:0]       prdata_q;
    logic              pready_q;
    logic              pslverr_q;
    tcm_state_e        state_q;
    tcm_state_e        state_d;

    // bus decode, clock select and event nets
    logic              wr_go;
    logic              rd_setup;
    logic              wr_ctl;
    logic [NUM_TAPS-1:0] tap_tick;
    logic              pin_rise;
    logic              pin_fall;
    logic              ff_rise;
    logic              ff_fall;
    logic              trig_edge;
    logic              tick;
    logic              cnt_go;
    logic              match0;
    logic              match1;
    logic              soft_cap;
    logic              cap0_ev;
    logic              cap1_ev;
    logic              ff_toggle;
    logic [1:0]        cap_mode;
    logic [2:0]        clk_sel;

    // write completes at the edge where the access phase sees pready
    assign wr_go    = psel && penable && pready_q && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign wr_ctl   = wr_go && blk_en_q;
    assign cap_mode = mode_q[POS_CAP_TIMING +: 2];
    assign clk_sel  = mode_q[POS_CLK_SEL +: 3];

    // prescaler taps
    tcm_prescaler u_presc (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .presc_run (presc_run_q && blk_en_q),
        .tap_tick  (tap_tick)
    );

    // edge detection on pin and timer flip-flop
    assign pin_rise  = timer_input_pin && !pin_prev_q;
    assign pin_fall  = !timer_input_pin && pin_prev_q;
    assign ff_rise   = ff_q && !ff_prev_q;
    assign ff_fall   = !ff_q && ff_prev_q;
    assign trig_edge = ctrl_q[BIT_TRIG_EDGE] ? pin_fall : pin_rise;

    // count source: pin edges or a prescaler tap
    assign tick = (clk_sel == CLK_PIN) ? pin_rise : tap_tick[clk_sel - 3'd1];

    // counting stops in idle mode unless idle running is enabled
    assign cnt_go = blk_en_q && (state_q == TCM_COUNT) && tick
                 && !(idle_mode && !ctrl_q[BIT_IDLE_RUN]);
    assign match0 = cnt_go && (cnt_q == cmp0_q);
    assign match1 = cnt_go && (cnt_q == cmp1_q);

    // capture events
    assign soft_cap = wr_ctl && hit(paddr, OFF_MODE) && !pwdata[BIT_SOFT_CAP];
    assign cap0_ev  = soft_cap
                   || (cap_mode == CAP_PIN && pin_rise)
                   || (cap_mode == CAP_FLIPFLOP && ff_rise);
    assign cap1_ev  = (cap_mode == CAP_PIN && pin_fall)
                   || (cap_mode == CAP_FLIPFLOP && ff_fall);
    assign ff_toggle = (match0 && fftgl_q[BIT_TGL_MATCH0 - 2]) || (match1 && fftgl_q[BIT_TGL_MATCH1 - 2])
                    || (cap0_ev && fftgl_q[BIT_TGL_CAP0 - 2]) || (cap1_ev && fftgl_q[BIT_TGL_CAP1 - 2]);

    // apb answer: ready one cycle after setup, no wait states
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= psel && !penable;
            pslverr_q <= psel && !penable && !mapped(paddr);
        end
    end

    // read data latched in setup; other registers read zero while disabled
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            prdata_q <= '0;
        else if (rd_setup)
        begin
            prdata_q <= '0;
            if (hit(paddr, OFF_ENABLE))
                prdata_q[BIT_BLOCK_EN] <= blk_en_q;
            else if (blk_en_q)
            begin
                if (hit(paddr, OFF_RUN))
                begin
                    prdata_q[BIT_PRESC_RUN] <= presc_run_q;
                    prdata_q[BIT_COUNT_RUN] <= cnt_run_q;
                end
                if (hit(paddr, OFF_CONTROL))
                    prdata_q[7:0] <= ctrl_q;
                if (hit(paddr, OFF_MODE))
                    prdata_q[7:0] <= mode_q | (8'h01 << BIT_SOFT_CAP);
                if (hit(paddr, OFF_FFCTRL))
                    prdata_q[7:0] <= FFCTRL_ONES | {2'b00, fftgl_q, 2'b00};
                if (hit(paddr, OFF_UPCOUNT))
                    prdata_q[15:0] <= cnt_q;
                if (hit(paddr, OFF_CMP0))
                    prdata_q[15:0] <= cmp0_buf_q;
                if (hit(paddr, OFF_CMP1))
                    prdata_q[15:0] <= cmp1_buf_q;
                if (hit(paddr, OFF_CAP0))
                    prdata_q[15:0] <= cap0_q;
                if (hit(paddr, OFF_CAP1))
                    prdata_q[15:0] <= cap1_q;
            end
        end
    end

    // enable register always writable; the rest only while enabled
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            blk_en_q    <= 1'b0;
            cnt_run_q   <= 1'b0;
            presc_run_q <= 1'b0;
            ctrl_q      <= RST_CONTROL;
            mode_q      <= RST_MODE;
            fftgl_q     <= RST_FFTGL;
        end
        else
        begin
            if (wr_go && hit(paddr, OFF_ENABLE))
                blk_en_q <= pwdata[BIT_BLOCK_EN];
            if (wr_ctl && hit(paddr, OFF_RUN))
            begin
                cnt_run_q   <= pwdata[BIT_COUNT_RUN];
                presc_run_q <= pwdata[BIT_PRESC_RUN];
            end
            if (wr_ctl && hit(paddr, OFF_CONTROL))
                ctrl_q <= {pwdata[7:5], 1'b0, pwdata[3:0]};                     // bit 4 always reads zero
            // soft capture bit is write-only and never stored
            if (wr_ctl && hit(paddr, OFF_MODE))
                mode_q <= pwdata[7:0] & ~(8'h01 << BIT_SOFT_CAP);
            if (wr_ctl && hit(paddr, OFF_FFCTRL))
                fftgl_q <= pwdata[5:2];
        end
    end

    // compare registers: staged when double buffered, loaded on compare 1 match or stop
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cmp0_buf_q <= RST_CMP;
            cmp1_buf_q <= RST_CMP;
            cmp0_q     <= RST_CMP;
            cmp1_q     <= RST_CMP;
        end
        else
        begin
            if (wr_ctl && hit(paddr, OFF_CMP0))
                cmp0_buf_q <= pwdata[15:0];
            if (wr_ctl && hit(paddr, OFF_CMP1))
                cmp1_buf_q <= pwdata[15:0];
            if (!ctrl_q[BIT_DBL_BUF])
            begin
                if (wr_ctl && hit(paddr, OFF_CMP0))
                    cmp0_q <= pwdata[15:0];
                if (wr_ctl && hit(paddr, OFF_CMP1))
                    cmp1_q <= pwdata[15:0];
            end
            else if (match1 || !cnt_run_q)
            begin
                cmp0_q <= cmp0_buf_q;
                cmp1_q <= cmp1_buf_q;
            end
        end
    end

    // start sequencer
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            TCM_STOPPED:
            begin
                if (cnt_run_q && blk_en_q && (!ctrl_q[BIT_SYNC_START] || sync_start_in))
                    state_d = ctrl_q[BIT_START_SRC] ? TCM_ARMED : TCM_COUNT;
            end
            TCM_ARMED:
            begin
                if (trig_edge)
                    state_d = TCM_COUNT;
            end
            TCM_COUNT:
                state_d = TCM_COUNT;
            default:
                state_d = TCM_STOPPED;
        endcase
        if (!cnt_run_q)
            state_d = TCM_STOPPED;
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q   <= TCM_STOPPED;
            running_q <= 1'b0;
        end
        else
        begin
            state_q   <= state_d;
            running_q <= (state_d == TCM_COUNT);
        end
    end

    // up-counter: stop clears, optional clear on compare 1 match
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            cnt_q <= '0;
        else if (!cnt_run_q)
            cnt_q <= '0;
        else if (cnt_go)
            cnt_q <= (mode_q[BIT_MATCH_CLR] && cnt_q == cmp1_q) ? 16'h0000 : cnt_q + 16'h0001;
    end

    // capture registers
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cap0_q <= '0;
            cap1_q <= '0;
        end
        else if (blk_en_q)
        begin
            if (cap0_ev)
                cap0_q <= cnt_q;
            if (cap1_ev)
                cap1_q <= cnt_q;
        end
    end

    // timer flip-flop: software force wins over event toggles
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ff_q       <= 1'b0;
            ff_prev_q  <= 1'b0;
            pin_prev_q <= 1'b0;
        end
        else
        begin
            ff_prev_q  <= ff_q;
            pin_prev_q <= timer_input_pin;
            if (wr_ctl && hit(paddr, OFF_FFCTRL) && pwdata[1:0] != 2'b11)
            begin
                case (pwdata[1:0])
                    FF_INVERT: ff_q <= !ff_q;
                    FF_SET:    ff_q <= 1'b1;
                    FF_CLEAR:  ff_q <= 1'b0;
                    default:   ff_q <= ff_q;
                endcase
            end
            else if (ff_toggle && blk_en_q)
                ff_q <= !ff_q;
        end
    end

    // outputs straight from flops
    assign prdata             = prdata_q;
    assign pready             = pready_q;
    assign pslverr            = pslverr_q;
    assign timer_flipflop_out = ff_q;
    assign count_running      = running_q;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    sequence s_mode_read;
        psel && !penable && !pwrite && blk_en_q && hit(paddr, OFF_MODE) ##1 psel && penable;
    endsequence

    chk_soft_cap_value: assert property (soft_cap |=> cap0_q == $past(cnt_q))
        else $error("soft capture did not take counter value");
    chk_soft_cap_readback: assert property (s_mode_read |-> prdata[BIT_SOFT_CAP])
        else $error("soft capture bit did not read as one");
    chk_pin_capture_fall: assert property (blk_en_q && cap_mode == CAP_PIN && pin_fall
        |=> cap1_q == $past(cnt_q))
        else $error("pin falling edge capture missed");
    chk_cap_disabled_hold: assert property (blk_en_q && cap_mode == CAP_OFF && !soft_cap
        |=> $stable(cap0_q) && $stable(cap1_q))
        else $error("capture happened while disabled");
    chk_ff_capture_rise: assert property (blk_en_q && cap_mode == CAP_FLIPFLOP && ff_rise
        |=> cap0_q == $past(cnt_q))
        else $error("flip-flop rising edge capture missed");
    chk_match_clear_zero: assert property (cnt_go && cnt_run_q && mode_q[BIT_MATCH_CLR] && cnt_q == cmp1_q
        |=> cnt_q == 16'h0000)
        else $error("counter not cleared on compare match");
    chk_no_clear_count: assert property (cnt_go && cnt_run_q && !mode_q[BIT_MATCH_CLR] && cnt_q == cmp1_q
        |=> cnt_q == $past(cnt_q) + 16'h0001)
        else $error("counter cleared although clearing disabled");
    chk_idle_stop_hold: assert property (idle_mode && !ctrl_q[BIT_IDLE_RUN] && cnt_run_q
        |=> $stable(cnt_q))
        else $error("counter moved in idle mode");
    chk_ext_trig_start: assert property (state_q == TCM_ARMED && cnt_run_q && trig_edge
        |=> state_q == TCM_COUNT && count_running)
        else $error("external trigger did not start count");
    chk_soft_start_go: assert property (state_q == TCM_STOPPED && cnt_run_q && blk_en_q
        && !ctrl_q[BIT_START_SRC] && !ctrl_q[BIT_SYNC_START] |=> state_q == TCM_COUNT)
        else $error("software start did not begin count");
    chk_sync_start_wait: assert property (state_q == TCM_STOPPED && ctrl_q[BIT_SYNC_START] && !sync_start_in
        |=> state_q == TCM_STOPPED)
        else $error("synchronous start began without group start");
    chk_dbuf_direct_load: assert property (wr_ctl && hit(paddr, OFF_CMP1) && !ctrl_q[BIT_DBL_BUF]
        |=> cmp1_q == $past(pwdata[15:0]))
        else $error("direct compare write not applied");
    chk_dbuf_staged_hold: assert property (wr_ctl && hit(paddr, OFF_CMP1) && ctrl_q[BIT_DBL_BUF]
        && cnt_run_q && !match1 |=> $stable(cmp1_q))
        else $error("staged compare write applied early");
    chk_presc_tap_src: assert property (blk_en_q && presc_run_q && cnt_run_q && state_q == TCM_COUNT
        && clk_sel == 3'b001 && !idle_mode && !mode_q[BIT_MATCH_CLR] |=> cnt_q == $past(cnt_q) + 16'h0001)
        else $error("divide-by-one tap did not count every cycle");

endmodule : tcm_timer

// ### common/tcm_pkg.sv
// timer capture/mode control: register map, field positions, reset values, codes
// assumes a 32-bit apb slave with word-aligned register offsets
package tcm_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_ENABLE   = 8'h00;
    localparam logic [7:0] OFF_RUN      = 8'h04;
    localparam logic [7:0] OFF_CONTROL  = 8'h08;
    localparam logic [7:0] OFF_MODE     = 8'h0c;
    localparam logic [7:0] OFF_FFCTRL   = 8'h10;
    localparam logic [7:0] OFF_UPCOUNT  = 8'h1c;
    localparam logic [7:0] OFF_CMP0     = 8'h20;
    localparam logic [7:0] OFF_CMP1     = 8'h24;
    localparam logic [7:0] OFF_CAP0     = 8'h28;
    localparam logic [7:0] OFF_CAP1     = 8'h2c;

    // enable / run fields
    localparam int BIT_BLOCK_EN   = 7;
    localparam int BIT_PRESC_RUN  = 2;
    localparam int BIT_COUNT_RUN  = 0;

    // control fields
    localparam int BIT_DBL_BUF    = 7;
    localparam int BIT_SYNC_START = 5;
    localparam int BIT_IDLE_RUN   = 3;
    localparam int BIT_TRIG_EDGE  = 1;
    localparam int BIT_START_SRC  = 0;

    // mode fields
    localparam int BIT_SOFT_CAP   = 6;
    localparam int POS_CAP_TIMING = 4;
    localparam int BIT_MATCH_CLR  = 3;
    localparam int POS_CLK_SEL    = 0;

    // flip-flop control fields
    localparam int BIT_TGL_CAP1   = 5;
    localparam int BIT_TGL_CAP0   = 4;
    localparam int BIT_TGL_MATCH1 = 3;
    localparam int BIT_TGL_MATCH0 = 2;

    // reset values and fixed read-back patterns
    localparam logic [7:0]  RST_CONTROL  = 8'h00;
    localparam logic [7:0]  RST_MODE     = 8'h00;
    localparam logic [3:0]  RST_FFTGL    = 4'h0;
    localparam logic [15:0] RST_CMP      = 16'h0000;
    localparam logic [7:0]  FFCTRL_ONES  = 8'hc3;

    // capture timing codes
    localparam logic [1:0] CAP_OFF      = 2'b00;
    localparam logic [1:0] CAP_PIN      = 2'b10;
    localparam logic [1:0] CAP_FLIPFLOP = 2'b11;

    // flip-flop force codes
    localparam logic [1:0] FF_INVERT    = 2'b00;
    localparam logic [1:0] FF_SET       = 2'b01;
    localparam logic [1:0] FF_CLEAR     = 2'b10;

    // count clock select: code 0 is the input pin, 1..7 prescaler taps
    localparam logic [2:0] CLK_PIN      = 3'b000;
    localparam int         NUM_TAPS     = 7;
    localparam int         TAP_DIV [NUM_TAPS] = '{1, 4, 16, 32, 64, 128, 256};
    localparam int         PRESC_W      = 8;

    // start sequencer
    typedef enum logic [1:0] {
        TCM_STOPPED = 2'b00,
        TCM_ARMED   = 2'b01,
        TCM_COUNT   = 2'b10
    } tcm_state_e;

endpackage : tcm_pkg

// ### rtl/tcm_prescaler.sv
// prescaler: divider that counts while presc_run is high, producing one-cycle tap pulses
// assumes the run level is synchronous to ref_clk; stop clears the divider
`timescale 1ns/1ps
module tcm_prescaler
    import tcm_pkg::*;
(
    // clock and reset
    input  wire logic                ref_clk,
    input  wire logic                rstn,
    // control
    input  wire logic                presc_run,
    // tap pulses, one per divide ratio
    output logic [NUM_TAPS-1:0]      tap_tick
);

    logic [PRESC_W-1:0] presc_q;

    // divider counts while running, clears when stopped
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            presc_q <= '0;
        else if (presc_run)
            presc_q <= presc_q + 8'h01;
        else
            presc_q <= '0;
    end

    // a tap fires when the low bits of the divider are all ones
    generate
        for (genvar i = 0; i < NUM_TAPS; i++)
        begin : g_tap
            localparam logic [PRESC_W-1:0] MASK = PRESC_W'(TAP_DIV[i] - 1);
            assign tap_tick[i] = presc_run && ((presc_q & MASK) == MASK);
        end
    endgenerate

endmodule : tcm_prescaler

// ### test/tb_top.sv
// tb_top: self-checking bench for one timer channel's mode, start and capture control
// assumes a zero-wait apb slave and timer pins synchronous to ref_clk
`timescale 1ns/1ps
module tb_top
    import tcm_pkg::*;
;
    // bench-driven inputs and design outputs
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        timer_input_pin = 1'b0;
    logic        idle_mode = 1'b0;
    logic        sync_start_in = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        timer_flipflop_out;
    logic        count_running;
    int          miscompares = 0;
    int          checks_done = 0;
    logic [31:0] rd;
    logic [31:0] a;
    logic [31:0] b;
    logic        er;
    int          d;

    // 100 mhz clock
    always #5 ref_clk = ~ref_clk;

    tcm_timer #(.ADDR_W(8)) u_tcm_timer (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_input_pin(timer_input_pin), .idle_mode(idle_mode), .sync_start_in(sync_start_in),
        .timer_flipflop_out(timer_flipflop_out), .count_running(count_running));

    // compare and count
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // verdict and end of run
    task conclude;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude

    task tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick

    // one apb transfer, held until pready is seen high
    task apb(input logic w, input logic [7:0] ad, input logic [31:0] dt);
        int i;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= dt;
        @(posedge ref_clk);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge ref_clk);
            i++;
        end
        while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1)
        begin
            miscompares++;
            conclude();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // pin pulse of a given high time
    task pulse(input int hi);
        timer_input_pin <= 1'b1;
        tick(hi);
        timer_input_pin <= 1'b0;
        tick(2);
    endtask : pulse

    // expected count after n cycles on a prescaler tap, with slack for start latency
    function logic [31:0] near(input logic [31:0] x, input int code, input int n);
        int e;
        e = n / TAP_DIV[code-1];
        return {31'h0, (int'(x) + 3 >= e) && (int'(x) <= e + 3)};
    endfunction : near

    initial
    begin
        void'($urandom(32'h55ee3ea0));
        tick(5);
        rstn <= 1'b1;
        // disabled block reads zero, then reset values and an unmapped place
        apb(1'b1, OFF_CONTROL, 32'hff);
        apb(1'b0, OFF_CONTROL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, OFF_ENABLE, 32'h80);
        apb(1'b0, OFF_CONTROL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, OFF_MODE, 32'h0);
        chk(rd, 32'h40);
        apb(1'b0, OFF_FFCTRL, 32'h0);
        chk(rd, 32'hc3);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, er}, 32'h1);
        // random control and mode values read back
        repeat (8)
        begin
            a = $urandom & 32'hff;
            apb(1'b1, OFF_CONTROL, a);
            apb(1'b0, OFF_CONTROL, 32'h0);
            chk(rd, a & 32'hef);
            b = $urandom & 32'hff;
            apb(1'b1, OFF_MODE, b);
            apb(1'b0, OFF_MODE, 32'h0);
            chk(rd, (b & 32'hbf) | 32'h40);
        end
        apb(1'b1, OFF_CONTROL, 32'h0);
        // every prescaler tap
        for (int k = 1; k < 8; k++)
        begin
            apb(1'b1, OFF_MODE, 32'h40 | k);
            apb(1'b1, OFF_RUN, 32'h5);
            tick(1024);
            apb(1'b0, OFF_UPCOUNT, 32'h0);
            apb(1'b1, OFF_RUN, 32'h0);
            chk(near(rd, k, 1026), 32'h1);
        end
        // pin clock, soft capture, write of one ignored
        apb(1'b1, OFF_MODE, 32'h40);
        apb(1'b1, OFF_RUN, 32'h1);
        tick(4);
        repeat (5) pulse(2);
        apb(1'b1, OFF_MODE, 32'h00);
        apb(1'b0, OFF_UPCOUNT, 32'h0);
        chk(rd, 32'h5);
        pulse(2);
        apb(1'b1, OFF_MODE, 32'h40);
        apb(1'b0, OFF_CAP0, 32'h0);
        chk(rd, 32'h5);
        // pin edge capture, then disabled and reserved codes
        apb(1'b1, OFF_RUN, 32'h0);
        apb(1'b1, OFF_MODE, 32'h61);
        apb(1'b1, OFF_RUN, 32'h5);
        tick(3);
        d = 3 + ($urandom % 20);
        pulse(d);
        tick(2);
        apb(1'b0, OFF_CAP0, 32'h0);
        a = rd;
        apb(1'b0, OFF_CAP1, 32'h0);
        chk(rd - a, 32'(d));
        b = rd;
        // later pin edges, so a wrong capture would hold other counts
        for (int c = 0; c < 2; c++)
        begin
            apb(1'b1, OFF_RUN, 32'h0);
            apb(1'b1, OFF_MODE, 32'h41 | (c << 4));
            apb(1'b1, OFF_RUN, 32'h5);
            tick(30);
            pulse(5);
            apb(1'b0, OFF_CAP0, 32'h0);
            chk(rd, a);
            apb(1'b0, OFF_CAP1, 32'h0);
            chk(rd, b);
        end
        // flip-flop edge capture, forced set then clear four cycles apart
        apb(1'b1, OFF_RUN, 32'h0);
        apb(1'b1, OFF_MODE, 32'h71);
        apb(1'b1, OFF_RUN, 32'h5);
        tick(3);
        apb(1'b1, OFF_FFCTRL, 32'h1);
        tick(1);
        chk({31'h0, timer_flipflop_out}, 32'h1);
        apb(1'b1, OFF_FFCTRL, 32'h2);
        tick(3);
        apb(1'b0, OFF_CAP0, 32'h0);
        a = rd;
        apb(1'b0, OFF_CAP1, 32'h0);
        chk(rd - a, 32'h4);
        // match clear on and off
        for (int k = 0; k < 2; k++)
        begin
            apb(1'b1, OFF_RUN, 32'h0);
            apb(1'b1, OFF_MODE, 32'h41 | (k << 3));
            apb(1'b1, OFF_CMP1, 32'h9);
            apb(1'b1, OFF_RUN, 32'h5);
            tick(30 + $urandom % 30);
            apb(1'b0, OFF_UPCOUNT, 32'h0);
            chk({31'h0, rd <= 32'h9}, 32'(k));
        end
        // staged compare holds until the old match, direct write does not
        for (int k = 0; k < 2; k++)
        begin
            apb(1'b1, OFF_RUN, 32'h0);
            apb(1'b1, OFF_CONTROL, 32'(k << 7));
            apb(1'b1, OFF_CMP1, 32'h14);
            apb(1'b1, OFF_RUN, 32'h5);
            tick(5);
            apb(1'b1, OFF_CMP1, 32'h3);
            tick(100);
            apb(1'b0, OFF_UPCOUNT, 32'h0);
            chk({31'h0, rd <= 32'h14}, 32'(k));
        end
        // idle mode stop or run
        idle_mode <= 1'b1;
        apb(1'b1, OFF_RUN, 32'h0);
        apb(1'b1, OFF_MODE, 32'h41);
        for (int k = 0; k < 2; k++)
        begin
            apb(1'b1, OFF_RUN, 32'h0);
            apb(1'b1, OFF_CONTROL, 32'(k << 3));
            apb(1'b1, OFF_RUN, 32'h5);
            tick(20);
            apb(1'b0, OFF_UPCOUNT, 32'h0);
            chk({31'h0, rd != 32'h0}, 32'(k));
        end
        idle_mode <= 1'b0;
        // external start: wrong edge ignored, chosen edge starts
        for (int k = 0; k < 2; k++)
        begin
            apb(1'b1, OFF_RUN, 32'h0);
            apb(1'b1, OFF_CONTROL, 32'h1 | (k << 1));
            timer_input_pin <= !k[0];
            tick(3);
            apb(1'b1, OFF_RUN, 32'h1);
            tick(4);
            timer_input_pin <= k[0];
            tick(4);
            chk({31'h0, count_running}, 32'h0);
            timer_input_pin <= !k[0];
            tick(4);
            chk({31'h0, count_running}, 32'h1);
        end
        // synchronous start waits for the group level
        apb(1'b1, OFF_RUN, 32'h0);
        apb(1'b1, OFF_CONTROL, 32'h20);
        apb(1'b1, OFF_RUN, 32'h1);
        tick(5);
        chk({31'h0, count_running}, 32'h0);
        sync_start_in <= 1'b1;
        tick(4);
        chk({31'h0, count_running}, 32'h1);
        conclude();
    end
endmodule : tb_top
